// *** pfs_fault_chan.v ***
// one fault channel: response policy, retry counter and delay timer
`default_nettype none
`include "pfs_regs.vh"
module pfs_fault_chan #(
  parameter CW = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire faultIn,
  input wire [2:0] respMode,
  input wire [3:0] retryCount,
  input wire [CW-1:0] delayCycles,
  input wire restartCmd,
  output reg shutdown,
  output reg crowbar,
  output wire faultFlag
);
  // ====================================================================
  // state machine
  localparam ST_RUN = 4'b0001;
  localparam ST_WARN = 4'b0010;
  localparam ST_OFF = 4'b0100;
  localparam ST_LATCH = 4'b1000;
  localparam [CW-1:0] ONE_TICK = 1;
  reg [3:0] state_reg;
  reg [CW-1:0] timer_reg;
  reg [3:0] tries_reg;
  wire infinite = (respMode == `PFS_RESP_RETRYINF);
  wire retrying = infinite || (respMode == `PFS_RESP_RETRYN);
  assign faultFlag = faultIn;
  // timer reloads on every entry to a waiting state, retries counted down
  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_RUN;
      timer_reg <= {CW{1'b0}};
      tries_reg <= 4'h0;
      shutdown <= 1'b0;
      crowbar <= 1'b0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          tries_reg <= retryCount;
          if (faultIn) begin
            case (respMode)
              `PFS_RESP_RIDE: state_reg <= ST_RUN;
              `PFS_RESP_DELAYED: begin
                state_reg <= ST_WARN;
                timer_reg <= delayCycles;
              end
              `PFS_RESP_CROWBAR: begin
                state_reg <= ST_LATCH;
                crowbar <= 1'b1;
                shutdown <= 1'b1;
              end
              default: begin
                state_reg <= ST_OFF;
                timer_reg <= delayCycles;
                shutdown <= 1'b1;
              end
            endcase
          end
        end
        ST_WARN: begin
          if (!faultIn) state_reg <= ST_RUN;
          else if (timer_reg == {CW{1'b0}}) begin
            state_reg <= ST_LATCH;
            shutdown <= 1'b1;
          end else timer_reg <= timer_reg - ONE_TICK;
        end
        ST_OFF: begin
          if (timer_reg != {CW{1'b0}} && retrying) timer_reg <= timer_reg - ONE_TICK;
          else if (!faultIn) begin
            state_reg <= ST_RUN;
            shutdown <= 1'b0;
          end else if (retrying) begin
            if (infinite || tries_reg != 4'h0) begin
              timer_reg <= delayCycles;
              if (!infinite) tries_reg <= tries_reg - 4'h1;
            end else state_reg <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          if (restartCmd) begin
            state_reg <= ST_RUN;
            shutdown <= 1'b0;
            crowbar <= 1'b0;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** pfs_regs.vh ***
// constants for the power stage fault supervisor
//
// Summary of operation
// - frequency reduction only when config bit 0 set and diode emulation active
// - full frequency at or above half nominal duty, linear drop below half
// - frequency reduced in discrete quantized steps between nominal and minimum; steps round down, so the lowest can sit below the minimum
// - frequency reduction off in sharing groups, with external sync, or driving sync
// - lockout strap low 3 V, high 10.8 V, open 4.5 V default
// - resistor strap or written threshold accepted between 2.85 V and 16 V
// - undervoltage response: ride through, delayed shutdown, or immediate shutdown with retries
// - after delayed undervoltage shutdown stay off until restart instruction
// - default undervoltage response is immediate shutdown, re-enable when fault clears
// - overvoltage above threshold drops power-good then runs selected response
// - overvoltage responses: shutdown with retries, or low-side crowbar until restart
// - default overvoltage response is immediate shutdown, re-enable when clear
// - with external clock only immediate shutdown is accepted for overvoltage
// - pre-bias below target becomes working target, both drivers on, ramp at soft-start; low side stays off while diode emulation is active
// - pre-biased start reaches target after exactly the configured ramp time
// - pre-bias above target becomes working target with matching duty
// - at ramp end assert power-good if not overvoltage, then ramp to target
// - pre-bias above overvoltage limit blocks turn-on and raises overvoltage fault
// - no pre-bias handling in sharing groups with tracking enabled
// - overcurrent responses: retry forever, retry count, delayed shutdown, ride through, immediate
// - default overcurrent response is immediate shutdown, re-enable when clear
// - low-side drive off at light load only on single-phase devices
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
// ====================================================================
// register offsets (8-bit word index)
`define PFS_ADDR_CTRL 4'h0
`define PFS_ADDR_UVRESP 4'h1
`define PFS_ADDR_OVRESP 4'h2
`define PFS_ADDR_OCRESP 4'h3
`define PFS_ADDR_UVTHR 4'h4
`define PFS_ADDR_DELAY 4'h5
`define PFS_ADDR_RAMP 4'h6
`define PFS_ADDR_TARGET 4'h7
`define PFS_ADDR_STATUS 4'h8
`define PFS_ADDR_FREQ 4'h9
`define PFS_ADDR_FMIN 4'ha
`define PFS_ADDR_DNOM 4'hb
// ====================================================================
// control bits
`define PFS_CTRL_AFC 0
`define PFS_CTRL_RESTART 1
`define PFS_CTRL_DIODE 2
// response codes
`define PFS_RESP_IMMED 3'h0
`define PFS_RESP_RIDE 3'h1
`define PFS_RESP_DELAYED 3'h2
`define PFS_RESP_RETRYN 3'h3
`define PFS_RESP_RETRYINF 3'h4
`define PFS_RESP_CROWBAR 3'h5
// lockout threshold in 0.01 V units
`define PFS_UV_LOW 16'd300
`define PFS_UV_OPEN 16'd450
`define PFS_UV_HIGH 16'd1080
`define PFS_UV_MIN 16'd285
`define PFS_UV_MAX 16'd1600
// strap codes
`define PFS_STRAP_LOW 2'h0
`define PFS_STRAP_OPEN 2'h1
`define PFS_STRAP_HIGH 2'h2
`define PFS_STRAP_RES 2'h3
// reset values
`define PFS_RST_DELAY 8'h10
`define PFS_RST_RAMP 8'h20
`define PFS_RST_TARGET 8'h80
`define PFS_RST_FREQ 8'hc8
`define PFS_RST_FMIN 8'h32
`define PFS_RST_DNOM 8'h40
// overvoltage limit about 15 % above target: target + target/8 + target/32
`define PFS_OV_PCT 8'd15
// frequency quantization step size as right shift
`define PFS_FSTEP_SH 3
`endif

// *** pfs_stage_model.sv ***
// behavioural power stage: output level, duty sense and comparator outputs
`default_nettype none
module pfs_stage_model (
  input wire logic sys_clk,
  input wire logic highDrive,
  input wire logic lowDrive,
  input wire logic [7:0] workTarget,
  input wire logic [7:0] preBias,
  input wire logic loadPre,
  input wire logic [7:0] dutyReq,
  input wire logic forceOv,
  input wire logic forceOc,
  output logic [7:0] senseLevel,
  output logic [7:0] dutyMeasured,
  output logic overVolt,
  output logic overCur
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // output level: an external source holds it while undriven, the stage slews one step a cycle
  always_ff @(posedge sys_clk) begin
    if (loadPre)
      senseLevel <= preBias;
    else if (highDrive && senseLevel < workTarget)
      senseLevel <= senseLevel + 8'h01;
    else if ((highDrive || lowDrive) && senseLevel > workTarget)
      senseLevel <= senseLevel - 8'h01;
  end
  // no high-side pulses means no measurable duty
  assign dutyMeasured = highDrive ? dutyReq : 8'h00;
  assign overVolt = forceOv;
  assign overCur = forceOc;
endmodule
`default_nettype wire

// *** pfs_supervisor.v ***
// power stage fault supervisor top: registers, faults, pre-bias start, frequency
`default_nettype none
`include "pfs_regs.vh"
module pfs_supervisor #(
  parameter CW = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire [1:0] input_lockout_threshold_strap,
  input wire [15:0] strapResistorThr,
  input wire inputUnderVolt,
  input wire outputOverVolt,
  input wire overCurrent,
  input wire [7:0] output_sense_input,
  input wire [7:0] dutyMeasured,
  input wire enableIn,
  input wire singlePhase,
  input wire shareGroup,
  input wire trackingOn,
  input wire syncAutoDetect,
  input wire extClockPresent,
  input wire syncDriving,
  input wire lightLoad,
  output reg high_side_gate_drive,
  output reg low_side_gate_drive,
  output reg power_good_output,
  output reg [7:0] workTarget,
  output reg [7:0] freqOut,
  output reg [15:0] uvThreshold,
  output wire afcActive
);
  // ====================================================================
  // configuration registers
  reg [7:0] ctrl_reg;
  reg [2:0] uvResp_reg;
  reg [2:0] ovResp_reg;
  reg [2:0] ocResp_reg;
  reg [3:0] uvTries_reg;
  reg [3:0] ovTries_reg;
  reg [3:0] ocTries_reg;
  reg [7:0] delay_reg;
  reg [7:0] ramp_reg;
  reg [7:0] target_reg;
  reg [7:0] freq_reg;
  reg [7:0] fmin_reg;
  reg [7:0] dnom_reg;
  reg [15:0] uvWritten_reg;
  reg uvWrittenValid_reg;
  reg restartPulse_reg;
  wire uvShut, ovShut, ovCrow, ocShut;
  wire extClock = extClockPresent;
  // ov response write: with an external clock only immediate shutdown is accepted
  wire ovRespOk = !extClock || (regWdata[2:0] == `PFS_RESP_IMMED);
  wire [15:0] uvWr = {6'h00, regWdata, 2'b00} + {8'h00, regWdata};
  // software writes; restart is a one-cycle self-clearing pulse
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      uvResp_reg <= `PFS_RESP_IMMED;
      ovResp_reg <= `PFS_RESP_IMMED;
      ocResp_reg <= `PFS_RESP_IMMED;
      uvTries_reg <= 4'h0;
      ovTries_reg <= 4'h0;
      ocTries_reg <= 4'h0;
      delay_reg <= `PFS_RST_DELAY;
      ramp_reg <= `PFS_RST_RAMP;
      target_reg <= `PFS_RST_TARGET;
      freq_reg <= `PFS_RST_FREQ;
      fmin_reg <= `PFS_RST_FMIN;
      dnom_reg <= `PFS_RST_DNOM;
      uvWritten_reg <= 16'h0000;
      uvWrittenValid_reg <= 1'b0;
      restartPulse_reg <= 1'b0;
    end else begin
      restartPulse_reg <= regWrite && regAddr == `PFS_ADDR_CTRL && regWdata[`PFS_CTRL_RESTART];
      if (regWrite) begin
        case (regAddr)
          `PFS_ADDR_CTRL: ctrl_reg <= regWdata & 8'hfd;
          `PFS_ADDR_UVRESP: begin
            uvResp_reg <= regWdata[2:0];
            uvTries_reg <= regWdata[7:4];
          end
          `PFS_ADDR_OVRESP: begin
            if (ovRespOk) begin
              ovResp_reg <= regWdata[2:0];
              ovTries_reg <= regWdata[7:4];
            end
          end
          `PFS_ADDR_OCRESP: begin
            ocResp_reg <= regWdata[2:0];
            ocTries_reg <= regWdata[7:4];
          end
          `PFS_ADDR_UVTHR: begin
            // value in 0.05 V units, clamped to the legal span
            if (uvWr < `PFS_UV_MIN)
              uvWritten_reg <= `PFS_UV_MIN;
            else if (uvWr > `PFS_UV_MAX)
              uvWritten_reg <= `PFS_UV_MAX;
            else
              uvWritten_reg <= uvWr;
            uvWrittenValid_reg <= 1'b1;
          end
          `PFS_ADDR_DELAY: delay_reg <= regWdata;
          `PFS_ADDR_RAMP: ramp_reg <= regWdata;
          `PFS_ADDR_TARGET: target_reg <= regWdata;
          `PFS_ADDR_FREQ: freq_reg <= regWdata;
          `PFS_ADDR_FMIN: fmin_reg <= regWdata;
          `PFS_ADDR_DNOM: dnom_reg <= regWdata;
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // ====================================================================
  // lockout threshold from strap, resistor strap or written value
  always @(posedge sys_clk) begin
    if (rst) begin
      uvThreshold <= `PFS_UV_OPEN;
    end else if (uvWrittenValid_reg) begin
      uvThreshold <= uvWritten_reg;
    end else begin
      case (input_lockout_threshold_strap)
        `PFS_STRAP_LOW: uvThreshold <= `PFS_UV_LOW;
        `PFS_STRAP_HIGH: uvThreshold <= `PFS_UV_HIGH;
        `PFS_STRAP_RES: begin
          if (strapResistorThr < `PFS_UV_MIN) uvThreshold <= `PFS_UV_MIN;
          else if (strapResistorThr > `PFS_UV_MAX) uvThreshold <= `PFS_UV_MAX;
          else uvThreshold <= strapResistorThr;
        end
        default: uvThreshold <= `PFS_UV_OPEN;
      endcase
    end
  end

  // ====================================================================
  // start-up sequencer with pre-bias handling
  localparam SS_IDLE = 5'b00001;
  localparam SS_DELAY = 5'b00010;
  localparam SS_RAMP = 5'b00100;
  localparam SS_ON = 5'b01000;
  localparam SS_OVBLK = 5'b10000;
  reg [4:0] ss_reg;
  reg [7:0] cnt_reg;
  reg [7:0] startV_reg;
  reg [15:0] acc_reg;
  reg preBiasOv_reg;
  wire anyShut = uvShut || ovShut || ocShut;
  wire [8:0] ovLimit = {1'b0, target_reg} + {4'h0, target_reg[7:3]} + {6'h00, target_reg[7:5]};
  wire sampleOv = {1'b0, output_sense_input} > ovLimit;
  wire preBiasAllowed = !(shareGroup && trackingOn);
  wire [8:0] span = {1'b0, target_reg} - {1'b0, startV_reg};
  wire [15:0] rampStep = (acc_reg + {7'h00, span}) / {8'h00, ramp_reg};
  // ramp: working target moves from the sampled level to the target in exactly ramp_reg steps
  always @(posedge sys_clk) begin
    if (rst) begin
      ss_reg <= SS_IDLE;
      cnt_reg <= 8'h00;
      startV_reg <= 8'h00;
      acc_reg <= 16'h0000;
      workTarget <= 8'h00;
      preBiasOv_reg <= 1'b0;
    end else if (!enableIn || anyShut) begin
      ss_reg <= SS_IDLE;
      workTarget <= 8'h00;
      preBiasOv_reg <= 1'b0;
    end else begin
      case (ss_reg)
        SS_IDLE: begin
          ss_reg <= SS_DELAY;
          cnt_reg <= delay_reg;
        end
        SS_DELAY: begin
          if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
          else if (preBiasAllowed && sampleOv) begin
            ss_reg <= SS_OVBLK;
            preBiasOv_reg <= 1'b1;
          end else begin
            ss_reg <= SS_RAMP;
            cnt_reg <= ramp_reg;
            acc_reg <= 16'h0000;
            startV_reg <= preBiasAllowed ? output_sense_input : 8'h00;
            workTarget <= preBiasAllowed ? output_sense_input : 8'h00;
          end
        end
        SS_RAMP: begin
          if (cnt_reg <= 8'h01) begin
            ss_reg <= SS_ON;
            workTarget <= target_reg;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
            if (startV_reg < target_reg) begin
              acc_reg <= acc_reg + {7'h00, span};
              workTarget <= startV_reg + rampStep[7:0];
            end
          end
        end
        SS_ON: workTarget <= target_reg;
        SS_OVBLK: preBiasOv_reg <= 1'b1;
        default: ss_reg <= SS_IDLE;
      endcase
    end
  end

  // ====================================================================
  // fault channels, one per fault kind
  pfs_fault_chan #(.CW(CW)) uvChan (
    .sys_clk(sys_clk), .rst(rst), .faultIn(inputUnderVolt), .respMode(uvResp_reg),
    .retryCount(uvTries_reg), .delayCycles(delay_reg), .restartCmd(restartPulse_reg),
    .shutdown(uvShut), .crowbar(), .faultFlag());
  pfs_fault_chan #(.CW(CW)) ovChan (
    .sys_clk(sys_clk), .rst(rst), .faultIn(outputOverVolt || preBiasOv_reg), .respMode(ovResp_reg),
    .retryCount(ovTries_reg), .delayCycles(delay_reg), .restartCmd(restartPulse_reg),
    .shutdown(ovShut), .crowbar(ovCrow), .faultFlag());
  pfs_fault_chan #(.CW(CW)) ocChan (
    .sys_clk(sys_clk), .rst(rst), .faultIn(overCurrent), .respMode(ocResp_reg),
    .retryCount(ocTries_reg), .delayCycles(delay_reg), .restartCmd(restartPulse_reg),
    .shutdown(ocShut), .crowbar(), .faultFlag());

  // ====================================================================
  // adaptive frequency reduction
  wire diodeEmu = ctrl_reg[`PFS_CTRL_DIODE] && singlePhase && lightLoad;
  assign afcActive = ctrl_reg[`PFS_CTRL_AFC] && diodeEmu && !shareGroup &&
    !(syncAutoDetect && extClockPresent) && !syncDriving;
  wire [15:0] slope = ({8'h00, freq_reg} - {8'h00, fmin_reg}) * {8'h00, dutyMeasured};
  wire [15:0] lin = (dnom_reg == 8'h00) ? 16'h0000 : ({slope[14:0], 1'b0} / {8'h00, dnom_reg});
  wire [15:0] fLin = lin + {8'h00, fmin_reg};
  // quantize: the low bits are dropped, so the frequency moves in coarse steps
  always @(posedge sys_clk) begin
    if (rst) freqOut <= `PFS_RST_FREQ;
    else if (afcActive && (dutyMeasured < {1'b0, dnom_reg[7:1]}) && fLin[15:8] == 8'h00)
      freqOut <= (fLin[7:0] >> `PFS_FSTEP_SH) << `PFS_FSTEP_SH;
    else freqOut <= freq_reg;
  end

  // ====================================================================
  // gate drives and power-good
  always @(posedge sys_clk) begin
    if (rst) begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      power_good_output <= 1'b0;
    end else begin
      if (ovCrow) begin
        high_side_gate_drive <= 1'b0;
        low_side_gate_drive <= 1'b1;
      end else if (anyShut || ss_reg == SS_IDLE || ss_reg == SS_DELAY || ss_reg == SS_OVBLK) begin
        high_side_gate_drive <= 1'b0;
        low_side_gate_drive <= 1'b0;
      end else begin
        high_side_gate_drive <= 1'b1;
        low_side_gate_drive <= !diodeEmu;
      end
      // power-good falls at once on overvoltage
      power_good_output <= ss_reg == SS_ON && !outputOverVolt && !anyShut && !sampleOv;
    end
  end

  // ====================================================================
  // read port, data in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rst) regRdata <= 8'h00;
    else if (regRead) begin
      case (regAddr)
        `PFS_ADDR_CTRL: regRdata <= ctrl_reg;
        `PFS_ADDR_UVRESP: regRdata <= {uvTries_reg, 1'b0, uvResp_reg};
        `PFS_ADDR_OVRESP: regRdata <= {ovTries_reg, 1'b0, ovResp_reg};
        `PFS_ADDR_OCRESP: regRdata <= {ocTries_reg, 1'b0, ocResp_reg};
        `PFS_ADDR_UVTHR: regRdata <= uvThreshold[9:2];
        `PFS_ADDR_DELAY: regRdata <= delay_reg;
        `PFS_ADDR_RAMP: regRdata <= ramp_reg;
        `PFS_ADDR_TARGET: regRdata <= target_reg;
        `PFS_ADDR_STATUS: regRdata <= {afcActive, power_good_output, ocShut, ovShut, uvShut, ovCrow, ss_reg == SS_ON, preBiasOv_reg};
        `PFS_ADDR_FREQ: regRdata <= freqOut;
        `PFS_ADDR_FMIN: regRdata <= fmin_reg;
        `PFS_ADDR_DNOM: regRdata <= dnom_reg;
        default: regRdata <= 8'h00;
      endcase
    end else regRdata <= 8'h00;
  end
endmodule
`default_nettype wire

// *** pfs_supervisor_sva.sv ***
// port-level assertions for the power stage fault supervisor
`default_nettype none
`include "pfs_regs.vh"
module pfs_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic extClockPresent,
  input wire logic inputUnderVolt,
  input wire logic outputOverVolt,
  input wire logic overCurrent,
  input wire logic singlePhase,
  input wire logic shareGroup,
  input wire logic syncAutoDetect,
  input wire logic syncDriving,
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  input wire logic power_good_output,
  input wire logic [15:0] uvThreshold,
  input wire logic afcActive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] uvMode_reg, ovMode_reg, ocMode_reg;
  // ==========================================================
  // shadow of the response modes; a refused write under an external clock is skipped too
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uvMode_reg <= 3'h0;
      ovMode_reg <= 3'h0;
      ocMode_reg <= 3'h0;
    end else if (regWrite) begin
      if (regAddr == `PFS_ADDR_UVRESP) uvMode_reg <= regWdata[2:0];
      if (regAddr == `PFS_ADDR_OVRESP && (!extClockPresent || regWdata[2:0] == 3'h0)) ovMode_reg <= regWdata[2:0];
      if (regAddr == `PFS_ADDR_OCRESP) ocMode_reg <= regWdata[2:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_afc_gate;
    afcActive |-> !shareGroup && !syncDriving && !(syncAutoDetect && extClockPresent);
  endproperty
  a_afc_gate: assert property (p_afc_gate) else $error("frequency reduction while disallowed");
  property p_afc_phase;
    afcActive |-> singlePhase;
  endproperty
  a_afc_phase: assert property (p_afc_phase) else $error("frequency reduction on multi-phase");
  property p_uv_range;
    uvThreshold >= `PFS_UV_MIN && uvThreshold <= `PFS_UV_MAX;
  endproperty
  a_uv_range: assert property (p_uv_range) else $error("lockout threshold out of range");
  property p_pg_ov;
    $rose(outputOverVolt) |-> ##[1:2] !power_good_output;
  endproperty
  a_pg_ov: assert property (p_pg_ov) else $error("power good kept over overvoltage");
  property p_uv_immed;
    uvMode_reg == 3'h0 && inputUnderVolt |-> ##[1:3] !high_side_gate_drive && !low_side_gate_drive;
  endproperty
  a_uv_immed: assert property (p_uv_immed) else $error("no shutdown on undervoltage");
  property p_ov_immed;
    ovMode_reg == 3'h0 && outputOverVolt |-> ##[1:3] !high_side_gate_drive && !low_side_gate_drive;
  endproperty
  a_ov_immed: assert property (p_ov_immed) else $error("no shutdown on overvoltage");
  property p_oc_immed;
    ocMode_reg == 3'h0 && overCurrent |-> ##[1:3] !high_side_gate_drive && !low_side_gate_drive;
  endproperty
  a_oc_immed: assert property (p_oc_immed) else $error("no shutdown on overcurrent");
  property p_crowbar;
    ovMode_reg == 3'h5 && outputOverVolt |-> ##[1:3] low_side_gate_drive && !high_side_gate_drive;
  endproperty
  a_crowbar: assert property (p_crowbar) else $error("crowbar drive missing");
endmodule
bind pfs_supervisor pfs_chk chk_u (.sys_clk, .rst, .regAddr, .regWdata, .regWrite, .extClockPresent,
  .inputUnderVolt, .outputOverVolt, .overCurrent, .singlePhase, .shareGroup, .syncAutoDetect, .syncDriving,
  .high_side_gate_drive, .low_side_gate_drive, .power_good_output, .uvThreshold, .afcActive);
`default_nettype wire

// *** pfs_tb.sv ***
// self-checking bench for the power stage fault supervisor
`default_nettype none
`include "pfs_regs.vh"
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin failCount++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, regWrite, regRead, inputUnderVolt, enableIn, singlePhase, shareGroup, trackingOn;
  logic syncAutoDetect, extClockPresent, syncDriving, lightLoad, loadPre, forceOv, forceOc, hsd, lsd, pg, afc, ovC, ocC;
  logic [3:0] regAddr, dq;
  logic [7:0] regWdata, regRdata, preBias, dutyReq, sense, duty, workTarget, freqOut, expRd;
  logic [1:0] strap;
  logic [15:0] thrR, uvThreshold;
  logic [5:0] okMask [3] = '{6'b001111, 6'b101001, 6'b011111};
  logic [7:0] expQ [$];
  logic rdPend = 1'b0;
  logic seenPre;
  int failCount = 0;
  int numChecks = 0;
  int cycles = 0;
  int nUp, n1;
  pfs_supervisor #(.CW(8)) dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .input_lockout_threshold_strap(strap),
    .strapResistorThr(thrR), .inputUnderVolt(inputUnderVolt), .outputOverVolt(ovC), .overCurrent(ocC),
    .output_sense_input(sense), .dutyMeasured(duty), .enableIn(enableIn), .singlePhase(singlePhase),
    .shareGroup(shareGroup), .trackingOn(trackingOn), .syncAutoDetect(syncAutoDetect),
    .extClockPresent(extClockPresent), .syncDriving(syncDriving), .lightLoad(lightLoad),
    .high_side_gate_drive(hsd), .low_side_gate_drive(lsd), .power_good_output(pg), .workTarget(workTarget),
    .freqOut(freqOut), .uvThreshold(uvThreshold), .afcActive(afc));
  pfs_stage_model stage_u (.sys_clk(sys_clk), .highDrive(hsd), .lowDrive(lsd), .workTarget(workTarget),
    .preBias(preBias), .loadPre(loadPre), .dutyReq(dutyReq), .forceOv(forceOv), .forceOc(forceOc),
    .senseLevel(sense), .dutyMeasured(duty), .overVolt(ovC), .overCur(ocC));
  // ==========================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      reportAndStop();
    end
  end
  // read data stand only in the cycle after the strobe, so compare exactly there
  always @(posedge sys_clk) begin
    if (rdPend) begin
      expRd = expQ.pop_front();
      `CHK(regRdata, expRd)
    end
    rdPend <= regRead;
  end
  // ==========================================================
  // bus and sequencing tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    expQ.push_back(e);
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic doReset();
    rst <= 1'b1;
    {enableIn, inputUnderVolt, forceOv, forceOc, extClockPresent} <= 5'h00;
    idle(8);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  // pre-bias is applied before enable; counts cycles until power good
  task automatic startUp(input logic [7:0] pre);
    wr(`PFS_ADDR_DELAY, 8'h04);
    wr(`PFS_ADDR_RAMP, 8'h08);
    regWrite <= 1'b0;
    preBias <= pre;
    loadPre <= 1'b1;
    @(posedge sys_clk);
    loadPre <= 1'b0;
    enableIn <= 1'b1;
    nUp = 0;
    seenPre = 1'b0;
    while (pg !== 1'b1 && nUp < 200) begin
      @(posedge sys_clk);
      nUp++;
      if (workTarget === pre) seenPre = 1'b1;
    end
  endtask
  task automatic faultRun(input int k, input int m);
    doReset();
    wr(4'(1 + k), {4'h1, 1'b0, 3'(m)});
    startUp(8'h45);
    inputUnderVolt <= k == 0;
    forceOv <= k == 1;
    forceOc <= k == 2;
    idle(100);
    `CHK(pg, m == 1)
    {inputUnderVolt, forceOv, forceOc} <= 3'h0;
    idle(60);
    `CHK(pg, !(m == 2 || m == 3 || m == 5))
    if (m == 5) `CHK(lsd, 1'b1)
    wr(`PFS_ADDR_CTRL, 8'h02);
    idle(1);
    while (pg !== 1'b1 && nUp < 400) begin
      @(posedge sys_clk);
      nUp++;
    end
    `CHK(pg, 1'b1)
  endtask
  task automatic reportAndStop();
    $display("checks=%0d mismatches=%0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {regWrite, regRead, enableIn, singlePhase, shareGroup, trackingOn, syncAutoDetect} = 7'h00;
    {extClockPresent, syncDriving, lightLoad, loadPre, forceOv, forceOc, inputUnderVolt} = 7'h00;
    {regAddr, regWdata, preBias, dutyReq, strap, thrR} = {4'h0, 24'h0, 2'h1, 16'd450};
    rst = 1'b1;
    void'($urandom(32'hc7f1));
    doReset();
    `CHK({hsd, lsd, pg, freqOut}, {3'b000, `PFS_RST_FREQ})
    rd(`PFS_ADDR_DELAY, `PFS_RST_DELAY);
    rd(`PFS_ADDR_RAMP, `PFS_RST_RAMP);
    rd(`PFS_ADDR_TARGET, `PFS_RST_TARGET);
    rd(`PFS_ADDR_FREQ, `PFS_RST_FREQ);
    rd(`PFS_ADDR_FMIN, `PFS_RST_FMIN);
    rd(`PFS_ADDR_DNOM, `PFS_RST_DNOM);
    rd(4'hf, 8'h00);
    for (int s = 0; s < 4; s++) begin
      thrR <= 16'd285 + 16'($urandom_range(1315));
      strap <= 2'(s);
      idle(3);
      `CHK(uvThreshold, s == 0 ? `PFS_UV_LOW : s == 1 ? `PFS_UV_OPEN : s == 2 ? `PFS_UV_HIGH : thrR)
    end
    for (int i = 0; i < 3; i++) begin
      wr(`PFS_ADDR_UVTHR, i == 0 ? 8'h10 : 8'($urandom_range(255, 57)));
      idle(3);
      `CHK(uvThreshold, i == 0 ? `PFS_UV_MIN : 16'(regWdata) * 16'd5)
    end
    extClockPresent <= 1'b1;
    wr(`PFS_ADDR_OVRESP, 8'h05);
    rd(`PFS_ADDR_OVRESP, 8'h00);
    extClockPresent <= 1'b0;
    wr(`PFS_ADDR_OVRESP, 8'h05);
    rd(`PFS_ADDR_OVRESP, 8'h05);
    doReset();
    startUp(8'h45);
    `CHK(seenPre, 1'b1)
    n1 = nUp;
    idle(60);
    `CHK(workTarget, `PFS_RST_TARGET)
    rd(`PFS_ADDR_STATUS, 8'h42);
    doReset();
    startUp(8'h8c);
    `CHK({seenPre, pg, nUp}, {2'b11, n1})
    idle(60);
    `CHK(workTarget, `PFS_RST_TARGET)
    wr(`PFS_ADDR_CTRL, 8'h05);
    {singlePhase, lightLoad} <= 2'b11;
    dutyReq <= 8'h30;
    idle(4);
    `CHK({afc, freqOut}, {1'b1, `PFS_RST_FREQ})
    dutyReq <= 8'h10;
    idle(4);
    `CHK(freqOut > 8'd117 && freqOut < 8'd133, 1'b1)
    for (int i = 0; i < 4; i++) begin
      dq = 4'(1 << i);
      {shareGroup, syncDriving, syncAutoDetect, extClockPresent, singlePhase} <= {dq[0], dq[1], dq[2], dq[2], !dq[3]};
      idle(4);
      `CHK({afc, freqOut}, {1'b0, `PFS_RST_FREQ})
    end
    {shareGroup, syncDriving, syncAutoDetect} <= 3'h0;
    doReset();
    startUp(8'ha0);
    `CHK({pg, hsd, lsd}, 3'b000)
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 6; m++)
        if (okMask[k][m]) faultRun(k, m);
    idle(4);
    reportAndStop();
  end
endmodule
`default_nettype wire
